/* design/toc_top.sv */
// APB-controlled bank of phase, neutral and residual time-overcurrent elements.
//
// Functional notes
// R1 - Open gate presents zero operating current to comparator and timers.
// R2 - Gate opening while timing drops pickup and time-out, then times reset.
// R3 - Torque point at one closes gate and routes current onward.
// R4 - Torque point is directional input AND torque-control term.
// R5 - Directional enable off forces directional input to one.
// R6 - Phase torque term written as constant zero is rejected.
// R7 - Torque term at zero opens gate, element nonoperational.
// R8 - Current above pickup and timing clears fully-reset flag.
// R9 - Completed curve timing asserts time-out flag.
// R10 - Reset mode yes emulates electromechanical reset, then flags fully reset.
// R11 - Reset mode no resets fully one power cycle after dropout.
// R12 - Curve select offers five US, five IEC, recloser and user curves.
// R13 - Time dial scales curve, range by family, not adder or floor.
// R14 - Constant adder adds to curve time; zero has no effect.
// R15 - Minimum response time floors the curve; zero disables it.
// R16 - Two neutral instances run on the neutral channel current.
// R17 - Neutral torque term may be constant zero, defeating that instance.
// R18 - Residual instance runs on the sum of three phase currents.
// R19 - Comparators and timers update once per processing tick, timers count in ticks.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "toc_defines.svh"

module toc_top #(
    parameter int NUM_INST = `TOC_NUM_INST,
    parameter int CUR_W    = 18
) (
    input  wire logic                MCLK,
    input  wire logic                SYS_RST,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                PROT_TICK,
    input  wire logic signed [15:0]  I_PHASE_A,
    input  wire logic signed [15:0]  I_PHASE_B,
    input  wire logic signed [15:0]  I_PHASE_C,
    input  wire logic signed [15:0]  I_NEUTRAL,
    input  wire logic [NUM_INST-1:0] DIR_PERMIT,
    input  wire logic [7:0]          LOGIC_BITS,
    output logic      [NUM_INST-1:0] PICKUP,
    output logic      [NUM_INST-1:0] TIMED_OUT,
    output logic      [NUM_INST-1:0] FULLY_RESET,
    output logic                     IRQ
);

    typedef enum logic [1:0] {
        TOC_BUS_IDLE   = 2'b01,
        TOC_BUS_ANSWER = 2'b10
    } toc_bus_type;

    toc_bus_type               bus_reg;
    logic                      directional_enable_reg;
    logic [`TOC_ST_WIDTH-1:0]  status_reg;
    logic [`TOC_ST_WIDTH-1:0]  mask_reg;
    logic [`TOC_ST_WIDTH-1:0]  status_set;
    toc_pkg::toc_setting_type  set_reg [NUM_INST];
    toc_pkg::toc_flags_type    flags   [NUM_INST];
    toc_pkg::toc_flags_type    flags_d_reg [NUM_INST];
    logic [NUM_INST-1:0]       torque_gate_point;
    logic [NUM_INST-1:0]       torque_term;
    logic [CUR_W-1:0]          op_cur  [NUM_INST];

    logic                      access_done;
    logic                      is_inst;
    logic [1:0]                sel_inst;
    logic [1:0]                sel_fld;
    toc_pkg::toc_setting_type  cand;
    logic                      cand_ok;
    logic                      addr_ok;
    logic [31:0]               rd_data;
    logic                      wr_setting;

    logic [15:0]               abs_a;
    logic [15:0]               abs_b;
    logic [15:0]               abs_c;
    logic [15:0]               abs_n;
    logic [15:0]               phase_max;
    logic signed [17:0]        resid_sum;
    logic [17:0]               resid_abs;

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        mag16 = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // Operating currents of the instance types.
    always_comb begin
        abs_a     = mag16(I_PHASE_A);
        abs_b     = mag16(I_PHASE_B);
        abs_c     = mag16(I_PHASE_C);
        abs_n     = mag16(I_NEUTRAL);
        phase_max = (abs_a > abs_b) ? abs_a : abs_b;
        phase_max = (phase_max > abs_c) ? phase_max : abs_c;
        resid_sum = 18'(I_PHASE_A) + 18'(I_PHASE_B) + 18'(I_PHASE_C); // [R18]
        resid_abs = resid_sum[17] ? 18'(-resid_sum) : 18'(resid_sum);
    end

    always_comb begin
        op_cur[`TOC_INST_PHASE]    = CUR_W'(phase_max);
        op_cur[`TOC_INST_NEUTRAL1] = CUR_W'(abs_n); // [R16]
        op_cur[`TOC_INST_NEUTRAL2] = CUR_W'(abs_n); // [R16]
        op_cur[`TOC_INST_RESIDUAL] = CUR_W'(resid_abs); // [R18]
    end

    // Address decode of the current access.
    assign access_done = PSEL && PENABLE && PREADY;
    assign is_inst     = (PADDR[7:4] >= `TOC_OFS_INST_BASE) &&
                         (PADDR[7:4] <= `TOC_OFS_INST_LAST) && (PADDR[1:0] == 2'h0);
    assign sel_inst    = 2'(PADDR[7:4] - `TOC_OFS_INST_BASE);
    assign sel_fld     = PADDR[3:2];

    // Candidate setting after merging the write data into one field.
    always_comb begin
        cand = set_reg[sel_inst];
        unique case (sel_fld)
            `TOC_FLD_PICKUP: begin
                cand.pickup = PWDATA[15:0];
            end
            `TOC_FLD_CURVE: begin
                cand.curve      = PWDATA[3:0];
                cand.reset_em   = PWDATA[4];
                cand.term_mode  = toc_pkg::toc_term_type'(PWDATA[9:8]);
                cand.term_index = PWDATA[14:12];
            end
            `TOC_FLD_DIAL: begin
                cand.dial = PWDATA[10:0];
            end
            `TOC_FLD_TIMES: begin
                cand.adder    = PWDATA[7:0];
                cand.min_resp = PWDATA[15:8];
            end
        endcase
    end

    // Setting check: curve family bounds the dial, phase refuses constant zero.
    always_comb begin
        cand_ok = 1'b1;
        if (cand.curve > `TOC_CURVE_LAST) begin // [R12]
            cand_ok = 1'b0;
        end
        if (cand.term_mode == toc_pkg::TOC_TERM_BAD) begin
            cand_ok = 1'b0;
        end
        if ((sel_inst == 2'(`TOC_INST_PHASE)) &&
            (cand.term_mode == toc_pkg::TOC_TERM_ZERO)) begin // [R6]
            cand_ok = 1'b0;
        end
        if (cand.curve <= `TOC_CURVE_US_LAST) begin // [R13]
            if ((cand.dial < `TOC_DIAL_US_MIN) || (cand.dial > `TOC_DIAL_US_MAX)) begin
                cand_ok = 1'b0;
            end
        end else if (cand.curve <= `TOC_CURVE_IEC_LAST) begin
            if ((cand.dial < `TOC_DIAL_IEC_MIN) || (cand.dial > `TOC_DIAL_IEC_MAX)) begin
                cand_ok = 1'b0;
            end
        end else begin
            if ((cand.dial < `TOC_DIAL_REC_MIN) || (cand.dial > `TOC_DIAL_REC_MAX)) begin
                cand_ok = 1'b0;
            end
        end
        if ((cand.adder > `TOC_TIME_MAX) || (cand.min_resp > `TOC_TIME_MAX)) begin // [R14] [R15]
            cand_ok = 1'b0;
        end
    end

    assign wr_setting = access_done && PWRITE && is_inst && cand_ok;

    // Read multiplexer and address check.
    always_comb begin
        rd_data = '0;
        addr_ok = 1'b1;
        if (is_inst) begin
            unique case (sel_fld)
                `TOC_FLD_PICKUP: begin
                    rd_data[15:0] = set_reg[sel_inst].pickup;
                end
                `TOC_FLD_CURVE: begin
                    rd_data[3:0]   = set_reg[sel_inst].curve;
                    rd_data[4]     = set_reg[sel_inst].reset_em;
                    rd_data[9:8]   = set_reg[sel_inst].term_mode;
                    rd_data[14:12] = set_reg[sel_inst].term_index;
                end
                `TOC_FLD_DIAL: begin
                    rd_data[10:0] = set_reg[sel_inst].dial;
                end
                `TOC_FLD_TIMES: begin
                    rd_data[7:0]  = set_reg[sel_inst].adder;
                    rd_data[15:8] = set_reg[sel_inst].min_resp;
                end
            endcase
        end else begin
            case (PADDR)
                `TOC_OFS_CTRL: begin
                    rd_data[`TOC_CTRL_DIR_EN_BIT] = directional_enable_reg;
                end
                `TOC_OFS_STATUS: begin
                    rd_data[`TOC_ST_WIDTH-1:0] = status_reg;
                end
                `TOC_OFS_MASK: begin
                    rd_data[`TOC_ST_WIDTH-1:0] = mask_reg;
                end
                `TOC_OFS_STATE: begin
                    rd_data[NUM_INST-1:0]            = PICKUP;
                    rd_data[NUM_INST+3:4]            = TIMED_OUT;
                    rd_data[NUM_INST+7:8]            = FULLY_RESET;
                    rd_data[NUM_INST+11:12]          = torque_gate_point;
                end
                default: begin
                    addr_ok = 1'b0;
                end
            endcase
        end
    end

    // Bus answer: one wait state, then a registered answer for one cycle.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bus_reg <= TOC_BUS_IDLE;
            PREADY  <= 1'b0;
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end else begin
            unique case (bus_reg)
                TOC_BUS_IDLE: begin
                    if (PSEL && PENABLE) begin
                        bus_reg <= TOC_BUS_ANSWER;
                        PREADY  <= 1'b1;
                        PRDATA  <= PWRITE ? 32'h00000000 : rd_data;
                        PSLVERR <= !addr_ok || (PWRITE && is_inst && !cand_ok);
                    end
                end
                TOC_BUS_ANSWER: begin
                    bus_reg <= TOC_BUS_IDLE;
                    PREADY  <= 1'b0;
                    PRDATA  <= '0;
                    PSLVERR <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            directional_enable_reg <= 1'b0;
            mask_reg               <= '0;
        end else if (access_done && PWRITE) begin
            if (PADDR == `TOC_OFS_CTRL) begin
                directional_enable_reg <= PWDATA[`TOC_CTRL_DIR_EN_BIT];
            end
            if (PADDR == `TOC_OFS_MASK) begin
                mask_reg <= PWDATA[`TOC_ST_WIDTH-1:0];
            end
        end
    end

    // Per-instance settings, torque gate and element.
    for (genvar i = 0; i < NUM_INST; i++) begin : g_inst
        always_ff @(posedge MCLK or posedge SYS_RST) begin
            if (SYS_RST) begin
                set_reg[i] <= '{pickup: `TOC_RST_PICKUP, curve: `TOC_RST_CURVE,
                                reset_em: 1'b1, term_mode: toc_pkg::TOC_TERM_ONE,
                                term_index: 3'h0, dial: `TOC_RST_DIAL,
                                adder: 8'h00, min_resp: 8'h00};
            end else if (wr_setting && (sel_inst == 2'(i))) begin // [R6]
                set_reg[i] <= cand;
            end
        end

        always_comb begin
            unique case (set_reg[i].term_mode)
                toc_pkg::TOC_TERM_ONE: torque_term[i] = 1'b1;
                toc_pkg::TOC_TERM_BIT: torque_term[i] = LOGIC_BITS[set_reg[i].term_index];
                default:               torque_term[i] = 1'b0; // [R7] [R17]
            endcase
        end

        // Directional input counts only while directional control is enabled.
        assign torque_gate_point[i] = (!directional_enable_reg || DIR_PERMIT[i]) // [R5]
                                      && torque_term[i]; // [R4] [R7]

        toc_element #(
            .CUR_W      (CUR_W),
            .CURVE_BASE (`TOC_CURVE_BASE)
        ) u_element (
            .clk     (MCLK),
            .rst     (SYS_RST),
            .tick    (PROT_TICK), // [R19]
            .gate    (torque_gate_point[i]), // [R3]
            .current (op_cur[i]),
            .setting (set_reg[i]),
            .flags   (flags[i])
        );

        assign PICKUP[i]      = flags[i].pickup;
        assign TIMED_OUT[i]   = flags[i].timed_out;
        assign FULLY_RESET[i] = flags[i].fully_reset;

        always_ff @(posedge MCLK or posedge SYS_RST) begin
            if (SYS_RST) begin
                flags_d_reg[i] <= '{pickup: 1'b0, timed_out: 1'b0, fully_reset: 1'b1};
            end else begin
                flags_d_reg[i] <= flags[i];
            end
        end

        assign status_set[i]     = flags[i].pickup && !flags_d_reg[i].pickup;
        assign status_set[i + 4] = flags[i].timed_out && !flags_d_reg[i].timed_out;
        assign status_set[i + 8] = flags[i].fully_reset && !flags_d_reg[i].fully_reset;
    end

    assign status_set[`TOC_ST_REJECT_BIT] = access_done && PWRITE && is_inst && !cand_ok;

    // Sticky events, cleared by writing one; a new event wins over the clear.
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            status_reg <= '0;
        end else if (access_done && PWRITE && (PADDR == `TOC_OFS_STATUS)) begin
            status_reg <= (status_reg & ~PWDATA[`TOC_ST_WIDTH-1:0]) | status_set;
        end else begin
            status_reg <= status_reg | status_set;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status_reg & mask_reg);
        end
    end

endmodule // toc_top

/* design/toc_defines.svh */
// Offsets, field positions, reset values and timing counts of the overcurrent block.
`ifndef TOC_DEFINES_SVH
`define TOC_DEFINES_SVH

`define TOC_NUM_INST        4
`define TOC_INST_PHASE      0
`define TOC_INST_NEUTRAL1   1
`define TOC_INST_NEUTRAL2   2
`define TOC_INST_RESIDUAL   3

`define TOC_OFS_CTRL        8'h00
`define TOC_OFS_STATUS      8'h04
`define TOC_OFS_MASK        8'h08
`define TOC_OFS_STATE       8'h0C
`define TOC_OFS_INST_BASE   4'h2
`define TOC_OFS_INST_LAST   4'h5
`define TOC_FLD_PICKUP      2'h0
`define TOC_FLD_CURVE       2'h1
`define TOC_FLD_DIAL        2'h2
`define TOC_FLD_TIMES       2'h3

`define TOC_CTRL_DIR_EN_BIT 0
`define TOC_ST_REJECT_BIT   12
`define TOC_ST_WIDTH        13

`define TOC_RST_PICKUP      16'hFFFF
`define TOC_RST_CURVE       4'h0
`define TOC_RST_DIAL        11'h064
`define TOC_CURVE_US_LAST   4'h4
`define TOC_CURVE_IEC_LAST  4'h9
`define TOC_CURVE_LAST      4'hB
`define TOC_DIAL_US_MIN     11'h032
`define TOC_DIAL_US_MAX     11'h5DC
`define TOC_DIAL_IEC_MIN    11'h005
`define TOC_DIAL_IEC_MAX    11'h064
`define TOC_DIAL_REC_MIN    11'h00A
`define TOC_DIAL_REC_MAX    11'h0C8
`define TOC_DIAL_UNITY      27'h0000064
`define TOC_TIME_MAX        8'hF0

`define TOC_TICKS_PER_CYCLE 3'h4
`define TOC_CURVE_BASE      {16'h0100, 16'h0080, 16'h0C00, 16'h0600, 16'h0300, 16'h0180, \
                             16'h00C0, 16'h0A00, 16'h0500, 16'h0280, 16'h0140, 16'h00A0}

`endif

/* design/toc_pkg.sv */
// Types shared by the overcurrent block.
package toc_pkg;

    typedef enum logic [1:0] {
        TOC_TERM_ZERO = 2'h0,
        TOC_TERM_ONE  = 2'h1,
        TOC_TERM_BIT  = 2'h2,
        TOC_TERM_BAD  = 2'h3
    } toc_term_type;

    typedef struct packed {
        logic [15:0]  pickup;
        logic [3:0]   curve;
        logic         reset_em;
        toc_term_type term_mode;
        logic [2:0]   term_index;
        logic [10:0]  dial;
        logic [7:0]   adder;
        logic [7:0]   min_resp;
    } toc_setting_type;

    typedef struct packed {
        logic pickup;
        logic timed_out;
        logic fully_reset;
    } toc_flags_type;

endpackage

/* design/toc_element.sv */
// One time-overcurrent element with torque gate, current-independent curve timer and reset timer.
`timescale 1ns/100ps
`include "toc_defines.svh"

module toc_element #(
    parameter int          CUR_W      = 18,
    parameter logic [191:0] CURVE_BASE = `TOC_CURVE_BASE
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     tick,
    input  wire logic                     gate,
    input  wire logic [CUR_W-1:0]         current,
    input  wire toc_pkg::toc_setting_type setting,
    output toc_pkg::toc_flags_type        flags
);

    typedef enum logic [2:0] {
        TOC_RESTING   = 3'b001,
        TOC_TIMING    = 3'b010,
        TOC_RESETTING = 3'b100
    } toc_phase_type;

    toc_phase_type     phase_reg, phase_next;
    logic [26:0]       acc_reg, acc_next;
    logic [2:0]        drop_reg, drop_next;
    logic [CUR_W-1:0]  op_current;
    logic              above;
    logic [26:0]       curve_time;
    logic [26:0]       target;
    logic [15:0]       base;

    // Open gate shows zero current to comparator and timers alike.
    assign op_current = gate ? current : '0; // [R1] [R3]
    assign above      = op_current > CUR_W'(setting.pickup);
    assign base       = CURVE_BASE[(11 - setting.curve) * 16 +: 16]; // [R12]

    // Dial scales the curve only; the adder is added after it, then the floor is applied.
    always_comb begin
        curve_time = 27'((27'(base) * 27'(setting.dial)) / `TOC_DIAL_UNITY); // [R13]
        curve_time = curve_time + 27'(setting.adder); // [R14]
        target     = (curve_time < 27'(setting.min_resp)) ? 27'(setting.min_resp)
                                                          : curve_time; // [R15]
        if (target == '0) begin
            target = 27'h0000001;
        end
    end

    always_comb begin
        phase_next = phase_reg;
        acc_next   = acc_reg;
        drop_next  = '0;
        if (above) begin
            phase_next = TOC_TIMING; // [R8]
            if (acc_reg < target) begin
                acc_next = acc_reg + 27'h0000001;
            end
        end else if (phase_reg != TOC_RESTING) begin
            phase_next = TOC_RESETTING; // [R2]
            if (setting.reset_em) begin
                if (acc_reg <= 27'h0000001) begin // [R10]
                    acc_next   = '0;
                    phase_next = TOC_RESTING;
                end else begin
                    acc_next = acc_reg - 27'h0000001;
                end
            end else if (drop_reg == `TOC_TICKS_PER_CYCLE - 3'h1) begin // [R11]
                acc_next   = '0;
                phase_next = TOC_RESTING;
            end else begin
                drop_next = drop_reg + 3'h1;
            end
        end
    end

    // State moves only on the processing tick.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_reg <= TOC_RESTING;
            acc_reg   <= '0;
            drop_reg  <= '0;
        end else if (tick) begin // [R19]
            phase_reg <= phase_next;
            acc_reg   <= acc_next;
            drop_reg  <= drop_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= '{pickup: 1'b0, timed_out: 1'b0, fully_reset: 1'b1};
        end else if (tick) begin
            flags.pickup      <= above; // [R2]
            flags.timed_out   <= above && (acc_next >= target); // [R9]
            flags.fully_reset <= !above && (phase_next == TOC_RESTING); // [R8] [R10] [R11]
        end
    end

endmodule // toc_element

/* bench/toc_top_sva.sv */
// Port-level checker of the overcurrent block.
`timescale 1ns/100ps
module toc_top_sva #(
    parameter int NUM_INST = 4
) (
    input wire logic                MCLK,
    input wire logic                SYS_RST,
    input wire logic                PSEL,
    input wire logic                PENABLE,
    input wire logic                PWRITE,
    input wire logic [31:0]         PRDATA,
    input wire logic                PREADY,
    input wire logic                PSLVERR,
    input wire logic                PROT_TICK,
    input wire logic [NUM_INST-1:0] PICKUP,
    input wire logic [NUM_INST-1:0] TIMED_OUT,
    input wire logic [NUM_INST-1:0] FULLY_RESET
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_answer;
        !PREADY ##1 PREADY;
    endsequence
    a_apb_wait: assert property (s_setup |=> s_answer)
        else $error("ready not one wait after setup");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer");
    a_err_ready: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
        else $error("refused read returned data");
    a_tick_only: assert property (!PROT_TICK |=> $stable({PICKUP, TIMED_OUT, FULLY_RESET}))
        else $error("flags moved without tick");
    a_trip_pickup: assert property ((TIMED_OUT & ~PICKUP) == '0)
        else $error("time-out without pickup");
    a_reset_clear: assert property ((PICKUP & FULLY_RESET) == '0)
        else $error("fully reset while picked up");
    a_reset_late: assert property ($rose(FULLY_RESET[0]) |-> !$past(PICKUP[0]))
        else $error("reset flag rose with pickup");
endmodule // toc_top_sva

bind toc_top toc_top_sva #(.NUM_INST(NUM_INST)) u_sva (.MCLK, .SYS_RST, .PSEL, .PENABLE,
    .PWRITE, .PRDATA, .PREADY, .PSLVERR, .PROT_TICK, .PICKUP, .TIMED_OUT, .FULLY_RESET);

/* bench/toc_line_model.sv */
// Line current source and processing tick generator facing the overcurrent block.
`timescale 1ns/100ps
module toc_line_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic signed [15:0] amp,
    input  wire logic signed [15:0] neu,
    input  wire logic               bal,
    output logic                    tick,
    output logic signed [15:0]      ia,
    output logic signed [15:0]      ib,
    output logic signed [15:0]      ic,
    output logic signed [15:0]      in_n
);
    logic [1:0] div_reg;
    // One tick every four clocks; a balanced set sums to zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 2'h0;
            tick    <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            tick    <= (div_reg == 2'h2);
        end
    end
    assign ia   = amp;
    assign ib   = bal ? -amp : amp;
    assign ic   = 16'sh0000;
    assign in_n = neu;
endmodule // toc_line_model

/* bench/test_time_overcurrent_torque_control.sv */
// Self-checking bench of the overcurrent block.
`timescale 1ns/100ps
module test_time_overcurrent_torque_control;
    logic               mclk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               tick;
    logic signed [15:0] ia, ib, ic, in_n;
    logic signed [15:0] amp = 16'sh0000;
    logic signed [15:0] neu = 16'sh0000;
    logic               bal = 1'b1;
    logic [3:0]         dir = 4'hF;
    logic [7:0]         lbits = 8'h00;
    logic [3:0]         pickup, timed, fres;
    logic               irq;
    logic [31:0]        r;
    logic               e;
    int                 err_count = 0;
    int                 check_count = 0;
    always #10 mclk = ~mclk;
    toc_line_model u_line (.clk(mclk), .rst(sys_rst), .amp(amp), .neu(neu), .bal(bal),
        .tick(tick), .ia(ia), .ib(ib), .ic(ic), .in_n(in_n));
    toc_top dut (.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PROT_TICK(tick), .I_PHASE_A(ia), .I_PHASE_B(ib), .I_PHASE_C(ic),
        .I_NEUTRAL(in_n), .DIR_PERMIT(dir), .LOGIC_BITS(lbits), .PICKUP(pickup),
        .TIMED_OUT(timed), .FULLY_RESET(fres), .IRQ(irq));
    task automatic give_verdict();
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    function automatic logic [31:0] fl();
        return {20'h0, pickup, timed, fres};
    endfunction
    // One APB transfer; waits for ready under a bound.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk iff tick);
        #1;
    endtask
    task automatic t_reset();
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk(r, 32'h0000FF00);
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk(r, 32'h00000110);
        apb(1'b0, 8'hFC, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000);
        chk(fl(), 32'h0000000F);
    endtask
    task automatic t_reject();
        apb(1'b1, 8'h24, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h28, 32'h00000020, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h24, 32'h0000010C, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h2C, 32'h000000F1, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h24, 32'h0, r, e);
        chk(r, 32'h00000110);
        apb(1'b1, 8'h08, 32'h00001000, r, e);
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk(r & 32'h00001000, 32'h00001000);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h04, 32'h00001000, r, e);
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h34, 32'h0, r, e);
        chk({31'h0, e}, 32'h0);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk(r, 32'h0000DF00);
    endtask
    task automatic t_trip();
        apb(1'b1, 8'h20, 32'h00000064, r, e);
        apb(1'b1, 8'h24, 32'h00000105, r, e);
        apb(1'b1, 8'h28, 32'h00000005, r, e);
        apb(1'b1, 8'h2C, 32'h0000F000, r, e);
        @(posedge mclk);
        amp <= 16'sd200;
        ticks(1);
        chk(fl(), 32'h0000010E);
        ticks(238);
        chk(fl(), 32'h0000010E);
        ticks(2);
        chk(fl(), 32'h0000011E);
        @(posedge mclk);
        amp <= 16'sd0;
        ticks(1);
        chk(fl(), 32'h0000000E);
        ticks(2);
        chk(fl(), 32'h0000000E);
        ticks(1);
        chk(fl(), 32'h0000000F);
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk(r, 32'h00000111);
    endtask
    task automatic t_gate();
        apb(1'b1, 8'h24, 32'h00003205, r, e);
        @(posedge mclk);
        lbits <= 8'h08;
        amp   <= 16'sd200;
        ticks(2);
        chk(fl(), 32'h0000010E);
        @(posedge mclk);
        lbits <= 8'h00;
        ticks(1);
        chk(fl(), 32'h0000000E);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk(r, 32'h0000CE00);
        ticks(3);
        chk(fl(), 32'h0000000F);
        apb(1'b1, 8'h00, 32'h00000001, r, e);
        @(posedge mclk);
        dir   <= 4'hE;
        lbits <= 8'h08;
        ticks(3);
        chk(fl(), 32'h0000000F);
        @(posedge mclk);
        dir <= 4'hF;
        ticks(1);
        chk(fl(), 32'h0000010E);
        apb(1'b1, 8'h00, 32'h0, r, e);
        @(posedge mclk);
        amp <= 16'sd0;
        ticks(4);
    endtask
    task automatic t_ground();
        apb(1'b1, 8'h40, 32'h0000000A, r, e);
        apb(1'b1, 8'h50, 32'h0000000A, r, e);
        @(posedge mclk);
        neu <= 16'sd50;
        amp <= 16'sd300;
        ticks(2);
        chk(fl(), 32'h0000050A);
        @(posedge mclk);
        bal <= 1'b0;
        ticks(2);
        chk(fl(), 32'h00000D02);
        @(posedge mclk);
        neu <= 16'sd0;
        ticks(1);
        chk(fl() & 32'h4, 32'h0);
        ticks(200);
        chk(fl() & 32'h4, 32'h4);
    endtask
    initial begin
        #2000000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_reject();
        t_trip();
        t_gate();
        t_ground();
        give_verdict();
    end
endmodule // test_time_overcurrent_torque_control
